// ### hdl/sfm_regs.svh
`ifndef SFM_REGS_SVH
`define SFM_REGS_SVH

// Register byte offsets on the Wishbone slave.
`define SFM_OFF_CTRL        8'h00
`define SFM_OFF_STATUS      8'h04
`define SFM_OFF_OC_LIMIT    8'h08
`define SFM_OFF_TH_LIMIT    8'h0C
`define SFM_OFF_TRK_LIMIT   8'h10
`define SFM_OFF_OS_LIMIT    8'h14
`define SFM_OFF_MAX_CUR     8'h18
`define SFM_OFF_POS_SCALE   8'h1C
`define SFM_OFF_MIN_VPOWER  8'h20
`define SFM_OFF_ACTIVE      8'h24

// Control register fields.
`define SFM_CTRL_SW_RESET   0
`define SFM_CTRL_PON_CHECK  1

// Status register fields.
`define SFM_ST_CODE_LSB     0
`define SFM_ST_LATCHED      8
`define SFM_ST_HW_CLASS     9
`define SFM_ST_BRAKE        10

// Reset values of the software registers.
`define SFM_RST_OC_LIMIT    32'h0000FFFF
`define SFM_RST_TH_LIMIT    32'h00FFFFFF
`define SFM_RST_TRK_LIMIT   32'h0000FFFF
`define SFM_RST_OS_LIMIT    32'h0000FFFF
`define SFM_RST_MAX_CUR     32'h0000FFFF
`define SFM_RST_POS_SCALE   5'h00
`define SFM_RST_MIN_VPOWER  10'h000
`define SFM_RST_PON_CHECK   1'b0

// Fixed thresholds.
`define SFM_OVERVOLT_V      10'd425
`define SFM_SUPPLY5_MIN_MV  13'd4500
`define SFM_OFFSET_PCT      8'd8
`define SFM_PCT_FULL        8'd100

// Error numbers shown in the error code monitor.
`define SFM_E_OVERCUR1      8'h02
`define SFM_E_OVERCUR2      8'h03
`define SFM_E_THERMAL       8'h04
`define SFM_E_OVERTEMP      8'h05
`define SFM_E_OVERVOLT      8'h06
`define SFM_E_INRUSH        8'h07
`define SFM_E_SUPPLY5       8'h08
`define SFM_E_CUR_OFFSET    8'h0A
`define SFM_E_TEMP_SENSOR   8'h0D
`define SFM_E_POS_OVF       8'h10
`define SFM_E_ZERO_LOST     8'h11
`define SFM_E_ENC_CRC       8'h12
`define SFM_E_ABS_POS       8'h13
`define SFM_E_ENC_AMPL      8'h14
`define SFM_E_ACQ_LOST      8'h15
`define SFM_E_TRACKING      8'h17
`define SFM_E_OVERSPEED     8'h18
`define SFM_E_POWER_ON      8'h1A

// Per error slot: set bit means hardware reset class, or brake on.
`define SFM_NUM_ERR         18
`define SFM_HW_MASK         18'h07EC0
`define SFM_BRAKE_MASK      18'h3FE68

`endif

// ### hdl/sfm_pkg.sv
package sfm_pkg;

  // Reset class needed to clear a latched error.
  typedef enum logic [0:0] {
    SFM_CLS_SW = 1'b0,
    SFM_CLS_HW = 1'b1
  } sfm_cls_t;

  typedef logic [7:0] sfm_code_t;

endpackage

// ### hdl/sfm_limit_cmp.sv
`timescale 1ns/1ps
module sfm_limit_cmp #(
  parameter int W      = 16,
  parameter bit SIGNED = 1'b1
) (
  // Clock and reset.
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Measurement and limit magnitude.
  input  wire logic [W-1:0] value_i,
  input  wire logic [W-1:0] limit_i,
  // Registered comparison result.
  output logic              exceeds_o
);

  logic [W:0] mag;

  initial begin
    if (W < 2 || W > 32) begin
      $error("sfm_limit_cmp: W out of range");
    end
  end

  // Magnitude of the measurement, one bit wider so the most negative fits.
  always_comb begin
    if (SIGNED && value_i[W-1]) begin
      mag = (W+1)'(~{1'b1, value_i}) + (W+1)'(1);
    end else begin
      mag = {1'b0, value_i};
    end
  end

  // Strictly greater than the limit raises the flag.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      exceeds_o <= 1'b0;
    end else begin
      exceeds_o <= (mag > {1'b0, limit_i});
    end
  end

endmodule // sfm_limit_cmp

// ### hdl/sfm_err_select.sv
`timescale 1ns/1ps
module sfm_err_select #(
  parameter int N = 18
) (
  // Clock and reset.
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // Active error conditions, slot 0 has the highest priority.
  input  wire logic [N-1:0]         req_i,
  // Registered lowest active slot.
  output logic                      valid_o,
  output logic [$clog2(N)-1:0]      idx_o
);

  localparam int IW = $clog2(N);

  logic [IW-1:0] pick;

  initial begin
    if (N < 2 || N > 64) begin
      $error("sfm_err_select: N out of range");
    end
  end

  // Scan from the top so the lowest slot is the last one kept.
  always_comb begin
    pick = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req_i[i]) begin
        pick = IW'(i);
      end
    end
  end

  // Register the choice so the code reaches the latch from a flip-flop.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      valid_o <= 1'b0;
      idx_o   <= '0;
    end else begin
      valid_o <= |req_i;
      idx_o   <= pick;
    end
  end

endmodule // sfm_err_select

// ### hdl/sfm_fault_monitor.sv
// Functional notes
// - Phase-one current magnitude above the overcurrent limit raises error 2, software class, brake off.
// - Phase-two current magnitude above the overcurrent limit raises error 3, software class, brake off.
// - A thermal accumulator above the thermal limit raises error 4, software class, brake off.
// - The heat-sink thermostat reporting above 70 C raises error 5, software class, brake on.
// - Power voltage above 425 V while a motor is powered raises error 6, software class, brake off.
// - Inrush or low power voltage with motor power enabled raises error 7, the rack inrush level comes from outside.
// - The internal 5 V supply below 4.5 V raises error 8, hardware class, brake on.
// - A current offset above 8 percent of the maximum current raises error 10, hardware class, brake off.
// - No answer from the temperature sensor raises error 13, software class, brake off.
// - Overflow of the scaled absolute encoder position raises error 16, hardware class, brake on.
// - Encoder zero not found, CRC failure and wrong position raise errors 17, 18 and 19, hardware class, brake on.
// - Too small analog amplitudes and lost acquisition raise errors 20 and 21, hardware class, brake on.
// - Tracking error magnitude above the tracking limit raises error 23, software class, brake on.
// - Velocity magnitude above the overspeed limit raises error 24, software class, brake on.
// - A power-on request with the first digital input low and the check off raises error 26, software class, brake on.
//
// The implementer's own choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
`include "sfm_regs.svh"
module sfm_fault_monitor
  import sfm_pkg::*;
#(
  parameter int CW = 16,
  parameter int TW = 24,
  parameter int PW = 24
) (
  // Clock and reset.
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // Wishbone classic slave.
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [7:0]    wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic      [31:0]   wb_dat_o,
  output logic               wb_ack_o,
  // Current and thermal measurements.
  input  wire logic [CW-1:0] phase1_current_i,
  input  wire logic [CW-1:0] phase2_current_i,
  input  wire logic [CW-1:0] current_offset_i,
  input  wire logic [TW-1:0] thermal_accumulator_i,
  input  wire logic          thermostat_hot_i,
  input  wire logic          temp_sensor_timeout_i,
  // Supply measurements and power state.
  input  wire logic [9:0]    power_voltage_i,
  input  wire logic [12:0]   supply5_mv_i,
  input  wire logic          motor_powered_i,
  input  wire logic          power_enable_i,
  input  wire logic          inrush_active_i,
  // Encoder status.
  input  wire logic [PW-1:0] enc_raw_position_i,
  input  wire logic          enc_zero_lost_i,
  input  wire logic          enc_crc_error_i,
  input  wire logic          enc_position_error_i,
  input  wire logic          enc_amplitude_low_i,
  input  wire logic          enc_acq_lost_i,
  // Motion measurements.
  input  wire logic [CW-1:0] tracking_error_i,
  input  wire logic [CW-1:0] velocity_i,
  // Power-on request and digital input.
  input  wire logic          power_on_req_i,
  input  wire logic          first_digital_input_i,
  // Fault outputs and the scaled encoder position.
  output sfm_code_t          error_code_o,
  output logic               fault_o,
  output logic               brake_on_o,
  output logic               hw_reset_needed_o,
  output logic [PW-1:0]      scaled_position_o
);

  localparam int NE = `SFM_NUM_ERR;
  localparam int IW = $clog2(NE);
  localparam logic [NE-1:0] HW_MASK    = `SFM_HW_MASK;
  localparam logic [NE-1:0] BRAKE_MASK = `SFM_BRAKE_MASK;

  initial begin
    if (CW < 4 || CW > 16 || TW < 2 || TW > 32 || PW < 2 || PW > 31) begin
      $error("sfm_fault_monitor: width parameter out of range");
    end
  end

  // Error number of each priority slot.
  localparam sfm_code_t SLOT_CODE [NE] = '{
    `SFM_E_OVERCUR1, `SFM_E_OVERCUR2, `SFM_E_THERMAL, `SFM_E_OVERTEMP,
    `SFM_E_OVERVOLT, `SFM_E_INRUSH, `SFM_E_SUPPLY5, `SFM_E_CUR_OFFSET,
    `SFM_E_TEMP_SENSOR, `SFM_E_POS_OVF, `SFM_E_ZERO_LOST, `SFM_E_ENC_CRC,
    `SFM_E_ABS_POS, `SFM_E_ENC_AMPL, `SFM_E_ACQ_LOST, `SFM_E_TRACKING,
    `SFM_E_OVERSPEED, `SFM_E_POWER_ON};

  // Byte-lane merge of a Wishbone write into a register.
  function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                             input logic [31:0] dat,
                                             input logic [3:0]  sel);
    lane_merge = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        lane_merge[8*b +: 8] = dat[8*b +: 8];
      end
    end
  endfunction

  // Software registers.
  logic [31:0]  oc_limit_q;
  logic [31:0]  th_limit_q;
  logic [31:0]  trk_limit_q;
  logic [31:0]  os_limit_q;
  logic [31:0]  max_cur_q;
  logic [4:0]   pos_scale_q;
  logic [9:0]   min_vpower_q;
  logic         pon_check_q;
  // Bus and latch state.
  logic         ack_q;
  logic [31:0]  rdata_q;
  logic         sw_clear;
  logic         wr_en;
  logic         rd_en;
  sfm_code_t    code_q;
  logic         latched_q;
  sfm_cls_t     cls_q;
  logic         brake_q;
  // Condition pipeline.
  logic [3:0]   cmp_hit;
  logic [CW-1:0] cmp_val [4];
  logic [CW-1:0] cmp_lim [4];
  logic         th_hit;
  logic [NE-1:0] cond;
  logic [NE-1:0] inline_q;
  logic         any_v;
  logic [IW-1:0] any_idx;
  logic         hw_v;
  logic [IW-1:0] hw_idx;
  logic [PW-1:0] ovf_mask;
  logic [CW-1:0] off_mag;
  logic [23:0]  off_scaled;
  logic [23:0]  max_scaled;

  // A request is served once, the answer comes one edge after the strobe.
  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q;
  assign rd_en = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_q;
  assign sw_clear = wr_en && (wb_adr_i == `SFM_OFF_CTRL) && wb_sel_i[0] &&
                    wb_dat_i[`SFM_CTRL_SW_RESET];
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

  // Acknowledge every access, mapped or not.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
    end
  end

  // Writable registers; writes to other offsets are dropped.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      oc_limit_q   <= `SFM_RST_OC_LIMIT;
      th_limit_q   <= `SFM_RST_TH_LIMIT;
      trk_limit_q  <= `SFM_RST_TRK_LIMIT;
      os_limit_q   <= `SFM_RST_OS_LIMIT;
      max_cur_q    <= `SFM_RST_MAX_CUR;
      pos_scale_q  <= `SFM_RST_POS_SCALE;
      min_vpower_q <= `SFM_RST_MIN_VPOWER;
      pon_check_q  <= `SFM_RST_PON_CHECK;
    end else if (wr_en) begin
      unique case (wb_adr_i)
        `SFM_OFF_CTRL: begin
          if (wb_sel_i[0]) begin
            pon_check_q <= wb_dat_i[`SFM_CTRL_PON_CHECK];
          end
        end
        `SFM_OFF_OC_LIMIT:
          oc_limit_q <= lane_merge(oc_limit_q, wb_dat_i, wb_sel_i);
        `SFM_OFF_TH_LIMIT:
          th_limit_q <= lane_merge(th_limit_q, wb_dat_i, wb_sel_i);
        `SFM_OFF_TRK_LIMIT:
          trk_limit_q <= lane_merge(trk_limit_q, wb_dat_i, wb_sel_i);
        `SFM_OFF_OS_LIMIT:
          os_limit_q <= lane_merge(os_limit_q, wb_dat_i, wb_sel_i);
        `SFM_OFF_MAX_CUR:
          max_cur_q <= lane_merge(max_cur_q, wb_dat_i, wb_sel_i);
        `SFM_OFF_POS_SCALE: begin
          if (wb_sel_i[0]) begin
            pos_scale_q <= wb_dat_i[4:0];
          end
        end
        `SFM_OFF_MIN_VPOWER: begin
          if (wb_sel_i[0]) begin
            min_vpower_q[7:0] <= wb_dat_i[7:0];
          end
          if (wb_sel_i[1]) begin
            min_vpower_q[9:8] <= wb_dat_i[9:8];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Read data; narrow fields sit low, the rest and unmapped offsets read 0.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= 32'h00000000;
    end else if (rd_en) begin
      unique case (wb_adr_i)
        `SFM_OFF_CTRL:
          rdata_q <= {30'h0, pon_check_q, 1'b0};
        `SFM_OFF_STATUS:
          rdata_q <= {21'h0, brake_q, cls_q, latched_q, code_q};
        `SFM_OFF_OC_LIMIT:   rdata_q <= {16'h0, oc_limit_q[15:0]};
        `SFM_OFF_TH_LIMIT:   rdata_q <= th_limit_q;
        `SFM_OFF_TRK_LIMIT:  rdata_q <= {16'h0, trk_limit_q[15:0]};
        `SFM_OFF_OS_LIMIT:   rdata_q <= {16'h0, os_limit_q[15:0]};
        `SFM_OFF_MAX_CUR:    rdata_q <= {16'h0, max_cur_q[15:0]};
        `SFM_OFF_POS_SCALE:  rdata_q <= {27'h0, pos_scale_q};
        `SFM_OFF_MIN_VPOWER: rdata_q <= {22'h0, min_vpower_q};
        `SFM_OFF_ACTIVE:     rdata_q <= {14'h0, cond};
        default:             rdata_q <= 32'h00000000;
      endcase
    end
  end

  // Signed magnitude compares: two phase currents, tracking and velocity.
  assign cmp_val[0] = phase1_current_i;
  assign cmp_val[1] = phase2_current_i;
  assign cmp_val[2] = tracking_error_i;
  assign cmp_val[3] = velocity_i;
  assign cmp_lim[0] = oc_limit_q[CW-1:0];
  assign cmp_lim[1] = oc_limit_q[CW-1:0];
  assign cmp_lim[2] = trk_limit_q[CW-1:0];
  assign cmp_lim[3] = os_limit_q[CW-1:0];
  for (genvar g = 0; g < 4; g++) begin : g_cmp
    sfm_limit_cmp #(
      .W      (CW),
      .SIGNED (1'b1)
    ) u_cmp (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .value_i   (cmp_val[g]),
      .limit_i   (cmp_lim[g]),
      .exceeds_o (cmp_hit[g])
    );
  end

  // Thermal accumulator against its limit, unsigned.
  sfm_limit_cmp #(
    .W      (TW),
    .SIGNED (1'b0)
  ) u_th_cmp (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .value_i   (thermal_accumulator_i),
    .limit_i   (th_limit_q[TW-1:0]),
    .exceeds_o (th_hit)
  );

  // Offset check by cross multiply: offset*100 > max*8, no division.
  always_comb begin
    off_mag    = current_offset_i[CW-1] ? CW'(-current_offset_i)
                                        : current_offset_i;
    off_scaled = 24'(off_mag) * 24'(`SFM_PCT_FULL);
    max_scaled = 24'(max_cur_q[15:0]) * 24'(`SFM_OFFSET_PCT);
  end

  // Top bits that a left shift by the scale would push out.
  assign ovf_mask = ~({PW{1'b1}} >> pos_scale_q);

  // Scaled absolute position handed on to the position loop.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      scaled_position_o <= '0;
    end else begin
      scaled_position_o <= enc_raw_position_i << pos_scale_q;
    end
  end

  // Flag conditions, registered so they line up with the comparators.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      inline_q <= '0;
    end else begin
      inline_q     <= '0;
      inline_q[3]  <= thermostat_hot_i;
      inline_q[4]  <= motor_powered_i &&
                      (power_voltage_i > `SFM_OVERVOLT_V);
      inline_q[5]  <= power_enable_i && (inrush_active_i ||
                      (power_voltage_i < min_vpower_q));
      inline_q[6]  <= supply5_mv_i < `SFM_SUPPLY5_MIN_MV;
      inline_q[7]  <= off_scaled > max_scaled;
      inline_q[8]  <= temp_sensor_timeout_i;
      inline_q[9]  <= |(enc_raw_position_i & ovf_mask);
      inline_q[10] <= enc_zero_lost_i;
      inline_q[11] <= enc_crc_error_i;
      inline_q[12] <= enc_position_error_i;
      inline_q[13] <= enc_amplitude_low_i;
      inline_q[14] <= enc_acq_lost_i;
      inline_q[17] <= power_on_req_i && !first_digital_input_i &&
                      !pon_check_q;
    end
  end

  // Full condition vector in priority order.
  always_comb begin
    cond     = inline_q;
    cond[0]  = cmp_hit[0];
    cond[1]  = cmp_hit[1];
    cond[2]  = th_hit;
    cond[15] = cmp_hit[2];
    cond[16] = cmp_hit[3];
  end

  // Lowest active error of any class.
  sfm_err_select #(
    .N (NE)
  ) u_sel_any (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .req_i   (cond),
    .valid_o (any_v),
    .idx_o   (any_idx)
  );

  // Lowest active error of the hardware class.
  sfm_err_select #(
    .N (NE)
  ) u_sel_hw (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .req_i   (cond & HW_MASK),
    .valid_o (hw_v),
    .idx_o   (hw_idx)
  );

  // Error latch: first error wins; a hardware error may replace a software
  // one, since a software reset could never clear it. An error still
  // present during a software reset is taken again, so none is lost.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      latched_q <= 1'b0;
      code_q    <= 8'h00;
      cls_q     <= SFM_CLS_SW;
      brake_q   <= 1'b0;
    end else if (!latched_q || (sw_clear && cls_q == SFM_CLS_SW)) begin
      latched_q <= any_v;
      code_q    <= any_v ? SLOT_CODE[any_idx] : 8'h00;
      cls_q     <= (any_v && HW_MASK[any_idx]) ? SFM_CLS_HW : SFM_CLS_SW;
      brake_q   <= any_v && BRAKE_MASK[any_idx];
    end else if (cls_q == SFM_CLS_SW && hw_v) begin
      code_q    <= SLOT_CODE[hw_idx];
      cls_q     <= SFM_CLS_HW;
      brake_q   <= BRAKE_MASK[hw_idx];
    end
  end

  // Fault outputs straight from the latch.
  assign error_code_o      = code_q;
  assign fault_o           = latched_q;
  assign brake_on_o        = brake_q;
  assign hw_reset_needed_o = latched_q && (cls_q == SFM_CLS_HW);

endmodule // sfm_fault_monitor

// ### tb/sfm_fault_monitor_asserts.sv
`timescale 1ns/1ps
module sfm_fault_monitor_asserts
  import sfm_pkg::*;
(
  // Clock, reset and bus handshake.
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic        wb_ack_o,
  // Watched fault inputs.
  input wire logic        thermostat_hot_i,
  input wire logic [9:0]  power_voltage_i,
  input wire logic        motor_powered_i,
  input wire logic [12:0] supply5_mv_i,
  input wire logic        enc_crc_error_i,
  // Fault outputs.
  input wire sfm_code_t   error_code_o,
  input wire logic        fault_o,
  input wire logic        hw_reset_needed_o
);
  // All checks share one clock and the asynchronous reset.
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // A request is answered after one cycle by a single pulse.
  ack_resp_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("Ack missing after a request.");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("Ack longer than one cycle.");
  // The fault flag goes with a nonzero latched number.
  code_flag_a: assert property (
    fault_o == (error_code_o != 8'h00))
    else $error("Fault flag and code disagree.");
  // Conditions latch three edges after they are sampled.
  hot_latch_a: assert property (
    !fault_o && thermostat_hot_i |-> ##3 fault_o)
    else $error("Overtemperature not latched.");
  volt_latch_a: assert property (
    !fault_o && motor_powered_i && power_voltage_i > 10'h1A9 |-> ##3 fault_o)
    else $error("Overvoltage not latched.");
  supply_hw_a: assert property (
    !hw_reset_needed_o && supply5_mv_i < 13'h1194 |-> ##3 hw_reset_needed_o)
    else $error("Supply drop not latched as hardware class.");
  crc_hw_a: assert property (
    !hw_reset_needed_o && enc_crc_error_i |-> ##3 hw_reset_needed_o)
    else $error("Encoder check failure not hardware class.");
  // A hardware class error stays put until the reset line.
  hw_hold_a: assert property (
    hw_reset_needed_o |=> hw_reset_needed_o && $stable(error_code_o))
    else $error("Hardware class error changed without reset.");
  // Main scenarios.
  hw_seen_c: cover property ($rose(hw_reset_needed_o));
  pon_seen_c: cover property (error_code_o == 8'h1A);
  wr_seen_c: cover property (wb_we_i && wb_ack_o);
endmodule // sfm_fault_monitor_asserts

// ### tb/sfm_drive_model.sv
`timescale 1ns/1ps
module sfm_drive_model (
  // Per slot, a set bit makes that fault condition present.
  input  wire logic [17:0] inj_i,
  // Sensed values and status lines.
  output logic [15:0] ph1_o, ph2_o, ofs_o, trk_o, vel_o,
  output logic [23:0] therm_o, raw_pos_o,
  output logic [9:0]  volt_o,
  output logic [12:0] mv_o,
  output logic        hot_o, tmo_o, inrush_o, zero_o, crc_o,
  output logic        perr_o, ampl_o, acq_o, pon_o, din_o
);
  // Healthy values sit on each limit, the raw position aside; a fault steps one past it.
  always_comb begin
    ph1_o = inj_i[0] ? 16'hFF9B : 16'h0064;
    ph2_o = inj_i[1] ? 16'h0065 : 16'h0064;
    therm_o = inj_i[2] ? 24'h000065 : 24'h000064;
    hot_o = inj_i[3];
    volt_o = inj_i[4] ? 10'h1AA : 10'h1A9;
    inrush_o = inj_i[5];
    mv_o = inj_i[6] ? 13'h1193 : 13'h1194;
    ofs_o = inj_i[7] ? 16'hFFAF : 16'h0050;
    tmo_o = inj_i[8];
    raw_pos_o = inj_i[9] ? 24'h1ABCDE : 24'h0ABCDE;
    zero_o = inj_i[10];
    crc_o = inj_i[11];
    perr_o = inj_i[12];
    ampl_o = inj_i[13];
    acq_o = inj_i[14];
    trk_o = inj_i[15] ? 16'hFF9B : 16'h0064;
    vel_o = inj_i[16] ? 16'h0065 : 16'h0064;
    pon_o = inj_i[17];
    din_o = !inj_i[17];
  end
endmodule // sfm_drive_model

// ### tb/sfm_fault_monitor_tb.sv
`timescale 1ns/1ps
`include "sfm_regs.svh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin \
  fail_count++; $display("BAD %0t got %0h want %0h", $time, a, e); end end
module sfm_fault_monitor_tb
  import sfm_pkg::*;
;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [15:0] phase1_current_i, phase2_current_i, current_offset_i;
  logic [15:0] tracking_error_i, velocity_i;
  logic [23:0] thermal_accumulator_i, enc_raw_position_i, scaled_position_o;
  logic [9:0] power_voltage_i;
  logic [12:0] supply5_mv_i;
  logic thermostat_hot_i, temp_sensor_timeout_i, motor_powered_i;
  logic power_enable_i, inrush_active_i, enc_zero_lost_i, enc_crc_error_i;
  logic enc_position_error_i, enc_amplitude_low_i, enc_acq_lost_i;
  logic power_on_req_i, first_digital_input_i, fault_o, brake_on_o;
  logic hw_reset_needed_o;
  sfm_code_t error_code_o;
  logic [17:0] inj;
  int fail_count, n_compared;
  // Expected number, class and brake of each slot.
  localparam sfm_code_t CODE [18] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
    8'h07, 8'h08, 8'h0A, 8'h0D, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15,
    8'h17, 8'h18, 8'h1A};
  localparam logic [17:0] HW = 18'h07EC0;
  localparam logic [17:0] BRK = 18'h3FE68;
  localparam logic [31:0] LIM [7] = '{32'h64, 32'h64, 32'h64, 32'h64,
    32'h3E8, 32'h4, 32'hC8};

  sfm_fault_monitor sfm_fault_monitor_inst (.*);
  sfm_drive_model sfm_drive_model_inst (
    .inj_i(inj), .ph1_o(phase1_current_i), .ph2_o(phase2_current_i),
    .ofs_o(current_offset_i), .trk_o(tracking_error_i), .vel_o(velocity_i),
    .therm_o(thermal_accumulator_i), .raw_pos_o(enc_raw_position_i),
    .volt_o(power_voltage_i), .mv_o(supply5_mv_i), .hot_o(thermostat_hot_i),
    .tmo_o(temp_sensor_timeout_i), .inrush_o(inrush_active_i),
    .zero_o(enc_zero_lost_i), .crc_o(enc_crc_error_i),
    .perr_o(enc_position_error_i), .ampl_o(enc_amplitude_low_i),
    .acq_o(enc_acq_lost_i), .pon_o(power_on_req_i),
    .din_o(first_digital_input_i));

  // Free running 25 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic report_and_stop;
    if (fail_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // One classic cycle; read data is taken at the ack edge.
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      report_and_stop();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // Limits, offset base, scale and minimum voltage.
  task automatic setup;
    foreach (LIM[i]) wb(1'b1, `SFM_OFF_OC_LIMIT + 8'(4 * i), LIM[i]);
  endtask

  task automatic hw_reset;
    rst_i <= 1'b1;
    tick(5);
    rst_i <= 1'b0;
    @(posedge clk_i);
    setup();
  endtask

  // Main sequence.
  initial begin
    fail_count = 0;
    n_compared = 0;
    inj = '0;
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i} = 15'h000F;
    wb_dat_i = '0;
    motor_powered_i = 1'b1;
    power_enable_i = 1'b1;
    tick(5);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, `SFM_OFF_STATUS, '0);
    `CHK(rd, 32'h0)
    wb(1'b1, 8'h40, 32'hFFFFFFFF);
    wb(1'b0, 8'h40, '0);
    `CHK(rd, 32'h0)
    setup();
    tick(2);
    `CHK(scaled_position_o, 24'hABCDE0)
    wb(1'b0, `SFM_OFF_OC_LIMIT, '0);
    `CHK(rd, 32'h64)
    // Each slot alone: number, class, brake and how it clears.
    for (int s = 0; s < 18; s++) begin
      inj <= 18'h1 << s;
      tick(4);
      wb(1'b0, `SFM_OFF_STATUS, '0);
      `CHK(rd[10:0], {BRK[s], HW[s], 1'b1, CODE[s]})
      `CHK(error_code_o, CODE[s])
      `CHK(brake_on_o, BRK[s])
      `CHK(hw_reset_needed_o, HW[s])
      inj <= '0;
      tick(3);
      wb(1'b1, `SFM_OFF_CTRL, 32'h1);
      tick(3);
      `CHK(error_code_o, HW[s] ? CODE[s] : 8'h00)
      if (HW[s]) hw_reset();
    end
    // The lower slot wins; a latched error ignores a new soft one but
    // yields to a hard one.
    inj <= 18'h00018;
    tick(4);
    inj <= 18'h00009;
    tick(4);
    `CHK(error_code_o, 8'h05)
    inj <= 18'h00808;
    tick(4);
    `CHK(error_code_o, 8'h12)
    inj <= '0;
    hw_reset();
    // Supply faults need motor power; enabled check hides the input.
    motor_powered_i <= 1'b0;
    power_enable_i <= 1'b0;
    inj <= 18'h00030;
    tick(4);
    `CHK(fault_o, 1'b0)
    inj <= '0;
    tick(3);
    motor_powered_i <= 1'b1;
    power_enable_i <= 1'b1;
    wb(1'b1, `SFM_OFF_CTRL, 32'h2);
    inj <= 18'h20000;
    tick(4);
    `CHK(fault_o, 1'b0)
    inj <= '0;
    // Power below the minimum raises error 7, which a soft reset cannot
    // clear while the condition stays.
    wb(1'b1, `SFM_OFF_MIN_VPOWER, 32'h1AA);
    tick(4);
    `CHK(error_code_o, 8'h07)
    wb(1'b0, `SFM_OFF_ACTIVE, '0);
    `CHK(rd, 32'h20)
    wb(1'b1, `SFM_OFF_CTRL, 32'h1);
    tick(3);
    `CHK(error_code_o, 8'h07)
    report_and_stop();
  end
endmodule // sfm_fault_monitor_tb

bind sfm_fault_monitor sfm_fault_monitor_asserts
  sfm_fault_monitor_asserts_inst (.*);
